// file: design/ple_pkg.sv
/*
 * Shared constants and types of the programmable logic equation engine:
 * sizes, the operand map, the operator codes and the packed carriers.
 * Assumes it is compiled before every file that names ple_pkg.
 */
package ple_pkg;

	// Sizes of the engine.
	localparam int NUM_EQ = 16;
	localparam int EQ_IDX_W = 4;
	localparam int NUM_CIN = 8;
	localparam int NUM_COUT = 4;
	localparam int NUM_ANA = 4;
	localparam int NUM_DIG = 4;
	localparam int NUM_CNT = 2;
	localparam int NUM_DIR = 2;
	localparam int NUM_REM = 8;
	localparam int NUM_DIRECT = 8;
	localparam int NUM_SOFT = 8;
	localparam int SEL_W = 7;
	localparam int OPD_NUM = 128;
	localparam int DLY_W = 8;
	localparam int VAL_W = 16;
	localparam int CNT_W = 16;
	localparam int SYNC_W = NUM_CIN + 2 * NUM_COUT;

	// Index of the last equation of a pass.
	localparam logic [EQ_IDX_W-1:0] EQ_LAST = 4'hF;

	// Operand map: bit positions in the operand vector.
	localparam int OPD_CONST0 = 0;
	localparam int OPD_CONST1 = 1;
	localparam int OPD_CIN_ON = 8;
	localparam int OPD_CIN_OFF = 16;
	localparam int OPD_COUT_VON = 24;
	localparam int OPD_COUT_CONTACT_VOLTAGE_ABSENT = 28;
	localparam int OPD_COUT_ION = 32;
	localparam int OPD_COUT_CONTACT_CURRENT_ABSENT = 36;
	localparam int OPD_ANA_PKP = 40;
	localparam int OPD_ANA_DPO = 44;
	localparam int OPD_ANA_OP = 48;
	localparam int OPD_DIG_PKP = 52;
	localparam int OPD_DIG_DPO = 56;
	localparam int OPD_DIG_OP = 60;
	localparam int OPD_CNT_ABOVE = 64;
	localparam int OPD_CNT_EQUAL = 66;
	localparam int OPD_CNT_BELOW = 68;
	localparam int OPD_DIR_BLOCK = 70;
	localparam int OPD_REMOTE = 72;
	localparam int OPD_DIRECT = 80;
	localparam int OPD_SOFT = 88;
	localparam int OPD_EQ_RESULT = 96;

	typedef enum logic [2:0] {
		ple_op_and,
		ple_op_or,
		ple_op_xor,
		ple_op_nand,
		ple_op_nor,
		ple_op_xnor,
		ple_op_timer,
		ple_op_latch
	} ple_op_e;

	// One programmed equation.
	typedef struct packed {
		ple_op_e op;
		logic inv_a;
		logic inv_b;
		logic [SEL_W-1:0] sel_a;
		logic [SEL_W-1:0] sel_b;
		logic [DLY_W-1:0] pu_dly;
		logic [DLY_W-1:0] rs_dly;
	} ple_eq_s;

	// Analog element: measurement and its settings.
	typedef struct packed {
		logic [VAL_W-1:0] value;
		logic [VAL_W-1:0] pickup;
		logic falling;
		logic [DLY_W-1:0] pu_dly;
		logic [DLY_W-1:0] rs_dly;
	} ple_ana_s;

	// Digital element settings.
	typedef struct packed {
		logic [SEL_W-1:0] src;
		logic [DLY_W-1:0] pu_dly;
		logic [DLY_W-1:0] rs_dly;
	} ple_dig_s;

	// Pulse counter settings.
	typedef struct packed {
		logic [SEL_W-1:0] src;
		logic [CNT_W-1:0] set_num;
		logic clear;
	} ple_cnt_s;

	// Pickup/reset timer state.
	typedef struct packed {
		logic op;
		logic [DLY_W-1:0] cnt;
	} ple_tmr_s;

	// Whole state of the engine.
	typedef struct packed {
		ple_eq_s [NUM_EQ-1:0] eqm;
		logic [NUM_EQ-1:0] result;
		ple_tmr_s [NUM_EQ-1:0] eq_tmr;
		logic [EQ_IDX_W-1:0] idx;
		logic pass_done;
		logic [NUM_ANA-1:0] ana_pkp;
		ple_tmr_s [NUM_ANA-1:0] ana_tmr;
		logic [NUM_DIG-1:0] dig_pkp;
		ple_tmr_s [NUM_DIG-1:0] dig_tmr;
		logic [NUM_CNT-1:0][CNT_W-1:0] cnt;
		logic [NUM_CNT-1:0] cnt_prev;
		logic [SYNC_W-1:0] sync1;
		logic [SYNC_W-1:0] sync2;
	} ple_state_s;

endpackage

// file: design/ple_engine.sv
/*
 * Programmable logic equation engine: a sequential evaluator of user
 * equations over single-bit operands, with element, counter and
 * timer operands and numbered equation result flags.
 * Assumes one 25 MHz clock, contact pins from outside the clock domain,
 * and element measurements and peer inputs from logic on the same clock.
 */
`timescale 1ns/100ps
module ple_engine (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Equation programming
	input wire logic prog_we,
	input wire logic [ple_pkg::EQ_IDX_W-1:0] prog_idx,
	input wire ple_pkg::ple_eq_s prog_eq,
	// Field pins
	input wire logic [ple_pkg::NUM_CIN-1:0] contact_in,
	input wire logic [ple_pkg::NUM_COUT-1:0] contact_voltage_sense,
	input wire logic [ple_pkg::NUM_COUT-1:0] contact_current_sense,
	// Element measurements and settings
	input wire ple_pkg::ple_ana_s [ple_pkg::NUM_ANA-1:0] ana_cfg,
	input wire ple_pkg::ple_dig_s [ple_pkg::NUM_DIG-1:0] dig_cfg,
	input wire ple_pkg::ple_cnt_s [ple_pkg::NUM_CNT-1:0] cnt_cfg,
	input wire logic [ple_pkg::NUM_DIR-1:0] dir_block_set,
	// Peer and communication inputs
	input wire logic [ple_pkg::NUM_REM-1:0] remote_in,
	input wire logic [ple_pkg::NUM_DIRECT-1:0] direct_in,
	input wire logic [ple_pkg::NUM_SOFT-1:0] soft_input_flag,
	// Results
	output logic [ple_pkg::NUM_EQ-1:0] equation_result_flag,
	output logic pass_done,
	output logic [ple_pkg::NUM_ANA-1:0] ana_operate_flag,
	output logic [ple_pkg::NUM_DIG-1:0] dig_operate_flag,
	output logic [ple_pkg::NUM_CNT-1:0] count_above_flag,
	output logic [ple_pkg::NUM_CNT-1:0] count_equal_flag,
	output logic [ple_pkg::NUM_CNT-1:0] count_below_flag
);

	ple_pkg::ple_state_s st;
	ple_pkg::ple_state_s next_st;
	logic [ple_pkg::OPD_NUM-1:0] opd;
	logic [ple_pkg::NUM_CIN-1:0] cin;
	logic [ple_pkg::NUM_COUT-1:0] cout_v;
	logic [ple_pkg::NUM_COUT-1:0] cout_i;

	// Pickup/reset timer stepped once per evaluation. A pickup delay of N
	// asserts after N+1 consecutive true evaluations; the reset delay
	// works the same way on false ones.
	function automatic ple_pkg::ple_tmr_s tmr_step(
		input logic cond,
		input logic [ple_pkg::DLY_W-1:0] pu,
		input logic [ple_pkg::DLY_W-1:0] rs,
		input ple_pkg::ple_tmr_s cur
	);
		ple_pkg::ple_tmr_s nxt;
		nxt = cur;
		if (cond == cur.op) begin
			nxt.cnt = '0;
		end else if (cond) begin
			if (cur.cnt >= pu) begin
				nxt.op = 1'b1;
				nxt.cnt = '0;
			end else begin
				nxt.cnt = cur.cnt + 1'b1;
			end
		end else begin
			if (cur.cnt >= rs) begin
				nxt.op = 1'b0;
				nxt.cnt = '0;
			end else begin
				nxt.cnt = cur.cnt + 1'b1;
			end
		end
		return nxt;
	endfunction

	// Only the second stage of each pin synchroniser is used.
	assign cin = st.sync2[ple_pkg::NUM_CIN-1:0];
	assign cout_v = st.sync2[ple_pkg::NUM_CIN +: ple_pkg::NUM_COUT];
	assign cout_i = st.sync2[ple_pkg::SYNC_W-1 -: ple_pkg::NUM_COUT];

	always_comb begin
		opd = '0;
		opd[ple_pkg::OPD_CONST0] = 1'b0;
		opd[ple_pkg::OPD_CONST1] = 1'b1;
		for (int i = 0; i < ple_pkg::NUM_CIN; i++) begin
			opd[ple_pkg::OPD_CIN_ON + i] = cin[i];
			opd[ple_pkg::OPD_CIN_OFF + i] = ~cin[i];
		end
		for (int i = 0; i < ple_pkg::NUM_COUT; i++) begin
			opd[ple_pkg::OPD_COUT_VON + i] = cout_v[i];
			opd[ple_pkg::OPD_COUT_CONTACT_VOLTAGE_ABSENT + i] = ~cout_v[i];
			opd[ple_pkg::OPD_COUT_ION + i] = cout_i[i];
			opd[ple_pkg::OPD_COUT_CONTACT_CURRENT_ABSENT + i] = ~cout_i[i];
		end
		for (int i = 0; i < ple_pkg::NUM_ANA; i++) begin
			opd[ple_pkg::OPD_ANA_PKP + i] = st.ana_pkp[i];
			opd[ple_pkg::OPD_ANA_DPO + i] = ~st.ana_pkp[i];
			opd[ple_pkg::OPD_ANA_OP + i] = st.ana_tmr[i].op;
		end
		for (int i = 0; i < ple_pkg::NUM_DIG; i++) begin
			opd[ple_pkg::OPD_DIG_PKP + i] = st.dig_pkp[i];
			opd[ple_pkg::OPD_DIG_DPO + i] = ~st.dig_pkp[i];
			opd[ple_pkg::OPD_DIG_OP + i] = st.dig_tmr[i].op;
		end
		for (int i = 0; i < ple_pkg::NUM_CNT; i++) begin
			opd[ple_pkg::OPD_CNT_ABOVE + i] =
				st.cnt[i] > cnt_cfg[i].set_num;
			opd[ple_pkg::OPD_CNT_EQUAL + i] =
				st.cnt[i] == cnt_cfg[i].set_num;
			opd[ple_pkg::OPD_CNT_BELOW + i] =
				st.cnt[i] < cnt_cfg[i].set_num;
		end
		for (int i = 0; i < ple_pkg::NUM_DIR; i++) begin
			opd[ple_pkg::OPD_DIR_BLOCK + i] = dir_block_set[i];
		end
		for (int i = 0; i < ple_pkg::NUM_REM; i++) begin
			opd[ple_pkg::OPD_REMOTE + i] = remote_in[i];
		end
		for (int i = 0; i < ple_pkg::NUM_DIRECT; i++) begin
			opd[ple_pkg::OPD_DIRECT + i] = direct_in[i];
		end
		for (int i = 0; i < ple_pkg::NUM_SOFT; i++) begin
			opd[ple_pkg::OPD_SOFT + i] = soft_input_flag[i];
		end
		for (int i = 0; i < ple_pkg::NUM_EQ; i++) begin
			opd[ple_pkg::OPD_EQ_RESULT + i] = st.result[i];
		end
	end

	always_comb begin
		ple_pkg::ple_eq_s cur;
		ple_pkg::ple_tmr_s t;
		logic a;
		logic b;
		logic res;
		logic pk;
		logic src;
		cur = st.eqm[st.idx];
		t = st.eq_tmr[st.idx];
		a = 1'b0;
		b = 1'b0;
		res = 1'b0;
		pk = 1'b0;
		src = 1'b0;
		next_st = st;

		next_st.sync1 = {contact_current_sense, contact_voltage_sense,
			contact_in};
		next_st.sync2 = st.sync1;

		// A program write lands in storage; the equation being evaluated
		// this cycle still uses its old contents.
		if (prog_we) begin
			next_st.eqm[prog_idx] = prog_eq;
		end

		a = opd[cur.sel_a] ^ cur.inv_a;
		b = opd[cur.sel_b] ^ cur.inv_b;

		unique case (cur.op)
			ple_pkg::ple_op_and: res = a & b;
			ple_pkg::ple_op_or: res = a | b;
			ple_pkg::ple_op_xor: res = a ^ b;
			ple_pkg::ple_op_nand: res = ~(a & b);
			ple_pkg::ple_op_nor: res = ~(a | b);
			ple_pkg::ple_op_xnor: res = ~(a ^ b);
			ple_pkg::ple_op_timer: begin
				t = tmr_step(a, cur.pu_dly, cur.rs_dly, t);
				res = t.op;
			end
			ple_pkg::ple_op_latch: begin
				// Reset dominates so a stuck set cannot hold a trip.
				res = b ? 1'b0 : (a ? 1'b1 : st.result[st.idx]);
			end
		endcase
		next_st.eq_tmr[st.idx] = t;

		next_st.result[st.idx] = res;

		next_st.idx = st.idx + 1'b1;
		next_st.pass_done = (st.idx == ple_pkg::EQ_LAST);

		// Elements update once, at the first equation of each pass.
		if (st.idx == '0) begin
			for (int i = 0; i < ple_pkg::NUM_ANA; i++) begin
				pk = ana_cfg[i].falling ?
					(ana_cfg[i].value < ana_cfg[i].pickup) :
					(ana_cfg[i].value > ana_cfg[i].pickup);
				next_st.ana_pkp[i] = pk;
				next_st.ana_tmr[i] = tmr_step(pk, ana_cfg[i].pu_dly,
					ana_cfg[i].rs_dly, st.ana_tmr[i]);
			end
			for (int i = 0; i < ple_pkg::NUM_DIG; i++) begin
				pk = opd[dig_cfg[i].src];
				next_st.dig_pkp[i] = pk;
				next_st.dig_tmr[i] = tmr_step(pk, dig_cfg[i].pu_dly,
					dig_cfg[i].rs_dly, st.dig_tmr[i]);
			end
			for (int i = 0; i < ple_pkg::NUM_CNT; i++) begin
				// Counting saturates so the above flag cannot wrap away.
				src = opd[cnt_cfg[i].src];
				next_st.cnt_prev[i] = src;
				if (cnt_cfg[i].clear) begin
					next_st.cnt[i] = '0;
				end else if (src && !st.cnt_prev[i] &&
					st.cnt[i] != '1) begin
					next_st.cnt[i] = st.cnt[i] + 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign equation_result_flag = st.result;
	assign pass_done = st.pass_done;

	always_comb begin
		for (int i = 0; i < ple_pkg::NUM_ANA; i++) begin
			ana_operate_flag[i] = st.ana_tmr[i].op;
		end
		for (int i = 0; i < ple_pkg::NUM_DIG; i++) begin
			dig_operate_flag[i] = st.dig_tmr[i].op;
		end
		for (int i = 0; i < ple_pkg::NUM_CNT; i++) begin
			count_above_flag[i] = opd[ple_pkg::OPD_CNT_ABOVE + i];
			count_equal_flag[i] = opd[ple_pkg::OPD_CNT_EQUAL + i];
			count_below_flag[i] = opd[ple_pkg::OPD_CNT_BELOW + i];
		end
	end

endmodule

// file: verif/ple_engine_monitor.sv
/* Checker of the engine's pass timing, result slots and counter flags.
   Assumes it is bound to ple_engine and shares its clock and reset. */
`timescale 1ns/100ps
module ple_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Watched ports
	input wire ple_pkg::ple_cnt_s [ple_pkg::NUM_CNT-1:0] cnt_cfg,
	input wire logic [15:0] equation_result_flag,
	input wire logic pass_done,
	input wire logic [3:0] ana_operate_flag,
	input wire logic [3:0] dig_operate_flag,
	input wire logic [1:0] count_above_flag,
	input wire logic [1:0] count_equal_flag,
	input wire logic [1:0] count_below_flag
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Mirror of the equation index, kept apart from the design on purpose.
	logic [3:0] ph;
	logic [4:0] clr_run;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ph <= 4'h0;
			clr_run <= 5'h00;
		end else begin
			ph <= ph + 4'h1;
			if (!cnt_cfg[0].clear)
				clr_run <= 5'h00;
			else if (clr_run != 5'h1F)
				clr_run <= clr_run + 5'h01;
		end
	end
	a_pass_period: assert property (pass_done |-> ##16 pass_done)
		else $error("pass pulse not repeated after 16 cycles");
	a_pass_gap: assert property (pass_done |=> !pass_done [*8])
		else $error("pass pulse repeated too early");
	a_pass_phase: assert property (pass_done |-> ph == 4'h0)
		else $error("pass pulse off the pass boundary");
	a_result_slot: assert property ((equation_result_flag
		^ $past(equation_result_flag)) == 16'h0000
		|| $onehot((equation_result_flag ^ $past(equation_result_flag))
		& (16'h0001 << $past(ph))))
		else $error("result flag changed outside its slot");
	a_elem_slot: assert property ($changed(ana_operate_flag)
		|| $changed(dig_operate_flag) |-> $past(ph) == 4'h0)
		else $error("element operate changed mid pass");
	a_count_one0: assert property ($onehot({count_above_flag[0],
		count_equal_flag[0], count_below_flag[0]}))
		else $error("counter 0 flags not exactly one");
	a_count_one1: assert property ($onehot({count_above_flag[1],
		count_equal_flag[1], count_below_flag[1]}))
		else $error("counter 1 flags not exactly one");
	a_clear_equal: assert property (clr_run > 5'h10 |->
		count_equal_flag[0] == (cnt_cfg[0].set_num == 16'h0000))
		else $error("cleared counter compare wrong");
	c_pass: cover property (pass_done);
	c_latch: cover property ($rose(equation_result_flag[8]));
	c_above: cover property ($rose(count_above_flag[0]));
endmodule
bind ple_engine ple_chk u_chk (.clk, .rst_b, .cnt_cfg,
	.equation_result_flag, .pass_done, .ana_operate_flag,
	.dig_operate_flag, .count_above_flag, .count_equal_flag,
	.count_below_flag);

// file: verif/ple_field_model.sv
/* Field and peer side of the engine: contacts and peer relay states.
   Assumes contact pins are asynchronous and peers run on clk. */
`timescale 1ns/100ps
module ple_field_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Requested states
	input wire logic contact_req,
	input wire logic dir_req,
	input wire logic [7:0] peer_req,
	// Drive into the engine
	output logic [7:0] contact_in,
	output logic [3:0] contact_voltage_sense,
	output logic [3:0] contact_current_sense,
	output logic [7:0] remote_in,
	output logic [7:0] direct_in,
	output logic [7:0] soft_input_flag,
	output logic [1:0] dir_block_set
);
	// Contacts change with no regard to the engine clock.
	assign contact_in = {8{contact_req}};
	assign contact_voltage_sense = {4{contact_req}};
	assign contact_current_sense = {4{contact_req}};
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			soft_input_flag <= 8'h00;
			remote_in <= 8'h00;
			direct_in <= 8'h00;
			dir_block_set <= 2'h0;
		end else begin
			soft_input_flag <= peer_req;
			remote_in <= {7'h00, peer_req[5]};
			direct_in <= {7'h00, peer_req[6]};
			dir_block_set <= {1'b0, dir_req};
		end
	end
endmodule

// file: verif/programmable_logic_equation_engine_test.sv
/* Self-checking bench of the engine: programs equations and checks
   results, element and counter flags. Assumes the field model. */
`timescale 1ns/100ps
module programmable_logic_equation_engine_test;
	logic clk, rst_b, prog_we, contact_req, dir_req, pass_done;
	logic [3:0] prog_idx, ana_operate_flag, dig_operate_flag;
	logic [3:0] contact_voltage_sense, contact_current_sense;
	logic [7:0] peer_req, contact_in, remote_in, direct_in, soft_input_flag;
	logic [1:0] dir_block_set, count_above_flag, count_equal_flag;
	logic [1:0] count_below_flag;
	logic [15:0] equation_result_flag;
	ple_pkg::ple_eq_s prog_eq;
	ple_pkg::ple_ana_s [3:0] ana_cfg;
	ple_pkg::ple_dig_s [3:0] dig_cfg;
	ple_pkg::ple_cnt_s [1:0] cnt_cfg;
	int err_count, checks_done;
	ple_engine DUT (.clk, .rst_b, .prog_we, .prog_idx, .prog_eq,
		.contact_in, .contact_voltage_sense, .contact_current_sense,
		.ana_cfg, .dig_cfg, .cnt_cfg, .dir_block_set, .remote_in,
		.direct_in, .soft_input_flag, .equation_result_flag, .pass_done,
		.ana_operate_flag, .dig_operate_flag, .count_above_flag,
		.count_equal_flag, .count_below_flag);
	ple_field_model FM (.clk, .rst_b, .contact_req, .dir_req, .peer_req,
		.contact_in, .contact_voltage_sense, .contact_current_sense,
		.remote_in, .direct_in, .soft_input_flag, .dir_block_set);
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic prog(input logic [3:0] k, input ple_pkg::ple_op_e op,
		input logic [6:0] a, input logic [6:0] b, input logic ib,
		input logic [7:0] pu, input logic [7:0] rs);
		@(posedge clk);
		prog_we <= 1'b1;
		prog_idx <= k;
		prog_eq <= '{op, 1'b0, ib, a, b, pu, rs};
		@(posedge clk);
		prog_we <= 1'b0;
	endtask
	// Returns at the falling edge that ends a pass, when all are settled.
	task automatic passes(input int n);
		repeat (n) begin
			@(negedge clk);
			while (pass_done !== 1'b1)
				@(negedge clk);
		end
	endtask
	task automatic peer(input logic [7:0] v);
		@(posedge clk);
		peer_req <= v;
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		tally_and_finish();
	end
	initial begin
		logic [7:0] lp [4] = '{8'h21, 8'h00, 8'h40, 8'h60};
		logic [1:0] le [4] = '{2'h3, 2'h3, 2'h2, 2'h2};
		logic [15:0] av [4] = '{16'h000A, 16'h0005, 16'h0005, 16'h000A};
		logic [15:0] pv [4] = '{16'h0005, 16'h0005, 16'h000A, 16'h000A};
		logic [3:0] fa = 4'hC;
		logic [3:0] ex = 4'h5;
		{rst_b, prog_we, contact_req, dir_req, prog_idx} = '0;
		{peer_req, prog_eq, ana_cfg, dig_cfg} = '0;
		dig_cfg[0] = '{7'h28, 8'h00, 8'h00};
		cnt_cfg = '{'{7'h00, 16'h0000, 1'b1}, '{7'h59, 16'h0002, 1'b1}};
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		passes(2);
		check("reset results", equation_result_flag, 16'h0000);
		check("cnt", {count_above_flag, count_below_flag}, 16'h0001);
		$display("test reset done");
		for (int b = 0; b < 2; b++) begin
			for (int k = 0; k < 6; k++)
				prog(4'(k), ple_pkg::ple_op_e'(k), 7'h01, 7'h00, b[0], 0, 0);
			passes(2);
			check("gates", 16'(equation_result_flag[5:0]),
				b ? 16'h0023 : 16'h000E);
		end
		$display("test gates done");
		prog(6, ple_pkg::ple_op_and, 7'h08, 7'h18, 0, 0, 0);
		prog(7, ple_pkg::ple_op_and, 7'h10, 7'h24, 0, 0, 0);
		for (int c = 1; c >= 0; c--) begin
			@(posedge clk);
			contact_req <= c[0];
			passes(3);
			check("contacts", 16'(equation_result_flag[7:6]),
				c ? 16'h0001 : 16'h0002);
		end
		$display("test contacts done");
		prog(8, ple_pkg::ple_op_latch, 7'h48, 7'h50, 0, 0, 0);
		prog(9, ple_pkg::ple_op_or, 7'h69, 7'h58, 0, 0, 0);
		for (int i = 0; i < 4; i++) begin
			peer(lp[i]);
			passes(2);
			check("latch", 16'(equation_result_flag[9:8]),
				16'(le[i]));
		end
		$display("test latch done");
		prog(12, ple_pkg::ple_op_timer, 7'h5A, 7'h00, 0, 2, 1);
		passes(1);
		peer(8'h04);
		passes(2);
		check("timer rise", 16'(equation_result_flag[12]), 0);
		passes(1);
		check("timer on", 16'(equation_result_flag[12]), 1);
		peer(8'h00);
		passes(1);
		check("timer hold", 16'(equation_result_flag[12]), 1);
		passes(1);
		check("timer off", 16'(equation_result_flag[12]), 0);
		$display("test timer done");
		prog(13, ple_pkg::ple_op_xor, 7'h28, 7'h2C, 0, 0, 0);
		prog(14, ple_pkg::ple_op_or, 7'h28, 7'h00, 0, 0, 0);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			ana_cfg[0] <= '{av[i], pv[i], fa[i], 8'h00, 8'h00};
			passes(4);
			check("element", {equation_result_flag[14:13], ana_operate_flag[0],
				dig_operate_flag[0]}, {ex[i], 1'b1, ex[i], ex[i]});
		end
		$display("test elements done");
		@(posedge clk);
		cnt_cfg[0].clear <= 1'b0;
		for (int i = 1; i < 4; i++) begin
			peer(8'h02);
			passes(1);
			peer(8'h00);
			passes(1);
			check("counter", {count_above_flag[0], count_equal_flag[0],
				count_below_flag[0]}, 16'h0001 << (i - 1));
		end
		$display("test counter done");
		prog(15, ple_pkg::ple_op_or, 7'h46, 7'h00, 0, 0, 0);
		for (int d = 1; d >= 0; d--) begin
			@(posedge clk);
			dir_req <= d[0];
			passes(3);
			check("block", 16'(equation_result_flag[15]), 16'(d));
		end
		$display("test block done");
		tally_and_finish();
	end
endmodule
